// >>> hw/pberc_checker.sv
// Function
// RQ1 - Error rate is errors over checked bits.
// RQ2 - Continuous mode restarts at once after any termination; here only the bit or error limit restarts it, a user stop does not.
// RQ3 - Continuous mode shows live results only in its first measurement.
// RQ4 - Single mode starts only on execute and stops for good.
// RQ5 - Execute starts a measurement only in single mode.
// RQ6 - Running single measurement refreshes shown results periodically.
// RQ7 - Maximum bit count ends the measurement; cause is bits.
// RQ8 - Maximum error count ends the measurement; cause is errors.
// RQ9 - Disabled or ignored bits are not counted.
// RQ10 - Cause shows user stop, maximum bits or maximum errors.
// RQ11 - Final results stay until a new measurement starts.
// RQ12 - Clock status shows whether clock edges arrive.
// RQ13 - Data is detected only from clocked samples.
// RQ14 - No sync before clock and data are detected.
// RQ15 - Internal PRBS is reference; a wrong polynomial never locks.
// RQ16 - Source sends the selected polynomial.
// RQ17 - PRBS15 and PRBS23 reference is inverted automatically.
// RQ18 - A false lock with half the bits wrong forces resync.
// RQ19 - Non-repeating data needs a restart line from the source; the checker has no restart input and checks only the PRBS polynomials.
// RQ20 - Each status is correct, missing or faulty.
// RQ21 - Bit and error counters are 32 bits wide.
// RQ22 - Stop on the first met criterion and name it.
// RQ23 - Reference period is two to the degree minus one.
// RQ24 - Seed from degree bits, lock after a matching run.
module pberc_checker
   import pberc_pkg::*;
(
   input wire logic sys_clk, // System clock, 10 MHz.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic clk_en, // Clock enable; state freezes while low.
   input wire logic meas_clk_pin, // Measurement clock from the device under test.
   input wire logic meas_data_pin, // Serial data from the device under test.
   input wire logic data_en_pin, // Data enable from the device under test.
   input wire logic run_enable, // Measurement switched on.
   input wire logic mode_single, // High selects single shot, low continuous.
   input wire logic exec_single, // One-cycle execute command.
   input wire logic stop_cmd, // One-cycle user stop command.
   input wire logic [2:0] prbs_sel, // Polynomial select.
   input wire logic [1:0] den_mode, // Data enable usage.
   input wire logic [1:0] ign_mode, // Pattern ignore selection.
   input wire logic max_bits_en, // Maximum bit criterion enabled.
   input wire logic [CNT_W-1:0] max_bits, // Maximum checked bits.
   input wire logic max_errs_en, // Maximum error criterion enabled.
   input wire logic [CNT_W-1:0] max_errs, // Maximum errors.
   output logic [CNT_W-1:0] live_bits, // Running checked bit count.
   output logic [CNT_W-1:0] live_errs, // Running error count.
   output logic [CNT_W-1:0] shown_bits, // Presented bit count.
   output logic [CNT_W-1:0] shown_errs, // Presented error count.
   output logic [PPM_W-1:0] ber_ppm, // Presented error rate in parts per million.
   output logic [1:0] term_cause, // Termination cause.
   output logic meas_busy, // Measurement running.
   output logic [1:0] clk_status, // Clock status.
   output logic [1:0] data_status, // Data status.
   output logic [1:0] sync_status // Synchronization status.
);

   function automatic logic prbs_fb(input logic [SR_W-1:0] s, input logic [2:0] sel);
      case (sel)
         PRBS_9: prbs_fb = s[8] ^ s[4];
         PRBS_11: prbs_fb = s[10] ^ s[8];
         PRBS_15: prbs_fb = s[14] ^ s[13];
         PRBS_16: prbs_fb = s[15] ^ s[13] ^ s[12] ^ s[10];
         PRBS_20: prbs_fb = s[19] ^ s[2];
         PRBS_21: prbs_fb = s[20] ^ s[18];
         PRBS_23: prbs_fb = s[22] ^ s[17];
         default: prbs_fb = s[8] ^ s[4];
      endcase
   endfunction : prbs_fb

   function automatic logic [4:0] prbs_deg(input logic [2:0] sel);
      case (sel)
         PRBS_9: prbs_deg = 5'h09;
         PRBS_11: prbs_deg = 5'h0B;
         PRBS_15: prbs_deg = 5'h0F;
         PRBS_16: prbs_deg = 5'h10;
         PRBS_20: prbs_deg = 5'h14;
         PRBS_21: prbs_deg = 5'h15;
         PRBS_23: prbs_deg = 5'h17;
         default: prbs_deg = 5'h09;
      endcase
   endfunction : prbs_deg

   // Pin synchronisers: bit 0 clock, 1 data, 2 enable; a third clock stage finds edges.
   logic [2:0] pin_s1_reg, pin_s2_reg;
   logic clk_s3_reg;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
         clk_s3_reg <= 1'b0;
      end else if (clk_en) begin
         pin_s1_reg <= {data_en_pin, meas_data_pin, meas_clk_pin};
         pin_s2_reg <= pin_s1_reg;
         clk_s3_reg <= pin_s2_reg[0];
      end
   end

   logic [7:0] gap_reg, gap_next;
   logic [1:0] clk_stat_reg, clk_stat_next, dat_stat_reg, dat_stat_next;
   logic [1:0] syn_stat_reg, syn_stat_next;
   logic dat_prev_reg, dat_prev_next;
   logic [7:0] idle_reg, idle_next;
   pberc_sync_type sy_reg, sy_next;
   logic [SR_W-1:0] sr_reg, sr_next;
   logic [5:0] cnt_reg, cnt_next, werr_reg, werr_next, ign_reg, ign_next;
   logic flock_reg, flock_next;
   pberc_meas_type ms_reg, ms_next;
   logic [CNT_W-1:0] bits_reg, bits_next, errs_reg, errs_next;
   logic [CNT_W-1:0] sbits_reg, sbits_next, serrs_reg, serrs_next;
   logic first_reg, first_next, busy_reg, busy_next;
   logic [1:0] cause_reg, cause_next;
   logic [9:0] refr_reg, refr_next;
   logic [NUM_W-1:0] num_reg, num_next;
   logic [CNT_W-1:0] den_reg, den_next;
   logic [CNT_W:0] rem_reg, rem_next;
   logic [PPM_W-1:0] q_reg, q_next, ppm_reg, ppm_next;
   logic [5:0] dcnt_reg, dcnt_next;
   logic dbusy_reg, dbusy_next;

   logic edge_c, bit_c, en_c, ign_c, rx_c, ref_c, err_c, cnt_c, load_c, hit_b, hit_e;
   logic [5:0] run_c;
   logic [CNT_W-1:0] nb_c, ne_c;
   logic [CNT_W:0] trial_c;

   always_comb begin
      gap_next = gap_reg;
      clk_stat_next = clk_stat_reg;
      dat_stat_next = dat_stat_reg;
      dat_prev_next = dat_prev_reg;
      idle_next = idle_reg;
      sy_next = sy_reg;
      sr_next = sr_reg;
      cnt_next = cnt_reg;
      werr_next = werr_reg;
      ign_next = ign_reg;
      flock_next = flock_reg;
      ms_next = ms_reg;
      bits_next = bits_reg;
      errs_next = errs_reg;
      sbits_next = sbits_reg;
      serrs_next = serrs_reg;
      first_next = first_reg;
      cause_next = cause_reg;
      refr_next = refr_reg;
      num_next = num_reg;
      den_next = den_reg;
      rem_next = rem_reg;
      q_next = q_reg;
      ppm_next = ppm_reg;
      dcnt_next = dcnt_reg;
      dbusy_next = dbusy_reg;
      load_c = 1'b0;
      ref_c = prbs_fb(sr_reg, prbs_sel);
      err_c = 1'b0;
      cnt_c = 1'b0;
      hit_b = 1'b0;
      hit_e = 1'b0;
      nb_c = bits_reg;
      ne_c = errs_reg;
      trial_c = '0;

      // Clock presence and plausibility from the sampled edges.
      edge_c = pin_s2_reg[0] & ~clk_s3_reg;
      bit_c = pin_s2_reg[1];
      if (edge_c) begin
         gap_next = 8'h00;
         clk_stat_next = (gap_reg < 8'(CLK_MIN_CYC - 1)) ? STAT_FAULT : STAT_OK; // RQ12 RQ20
      end else if (gap_reg < 8'(CLK_LOSS_CYC)) begin
         gap_next = gap_reg + 8'h01;
      end else begin
         clk_stat_next = STAT_MISSING; // RQ12
      end

      // Data is judged only on clocked samples.
      if (clk_stat_reg != STAT_OK) begin
         dat_stat_next = (clk_stat_reg == STAT_FAULT) ? STAT_FAULT : STAT_MISSING; // RQ13 RQ20
         idle_next = 8'h00;
      end else if (edge_c) begin
         dat_prev_next = bit_c;
         if (bit_c != dat_prev_reg) begin
            idle_next = 8'h00;
            dat_stat_next = STAT_OK; // RQ13
         end else if (idle_reg < 8'(DATA_IDLE_BITS)) begin
            idle_next = idle_reg + 8'h01;
         end else begin
            dat_stat_next = STAT_MISSING; // RQ13
         end
      end

      en_c = edge_c & ((den_mode == DEN_OFF) | ((den_mode == DEN_HIGH) & pin_s2_reg[2]) |
         ((den_mode == DEN_LOW) & ~pin_s2_reg[2]));
      if (ign_mode != IGN_OFF && bit_c == (ign_mode == IGN_ONES)) begin
         run_c = (ign_reg == 6'(IGN_RUN)) ? ign_reg : ign_reg + 6'h01;
      end else begin
         run_c = 6'h00;
      end
      ign_c = (run_c == 6'(IGN_RUN));
      rx_c = bit_c ^ ((prbs_sel == PRBS_15) | (prbs_sel == PRBS_23)); // RQ17

      if (clk_stat_reg != STAT_OK || dat_stat_reg != STAT_OK) begin
         sy_next = SY_SEED; // RQ14
         cnt_next = 6'h00;
      end else if (en_c) begin
         ign_next = run_c;
         case (sy_reg)
            SY_SEED: begin
               sr_next = {sr_reg[SR_W-2:0], rx_c}; // RQ24
               if (cnt_reg == 6'(prbs_deg(prbs_sel) - 5'h01)) begin
                  sy_next = SY_CHECK;
                  cnt_next = 6'h00;
               end else begin
                  cnt_next = cnt_reg + 6'h01;
               end
            end
            SY_CHECK: begin
               // Free-running reference of period two to the degree minus one.
               sr_next = {sr_reg[SR_W-2:0], ref_c}; // RQ15 RQ23
               if (!ign_c && rx_c != ref_c) begin
                  sy_next = SY_SEED; // RQ15
                  cnt_next = 6'h00;
               end else if (cnt_reg == 6'(SYNC_RUN - 1)) begin
                  sy_next = SY_LOCK; // RQ24
                  cnt_next = 6'h00;
                  werr_next = 6'h00;
                  flock_next = 1'b0;
               end else begin
                  cnt_next = cnt_reg + 6'h01;
               end
            end
            SY_LOCK: begin
               sr_next = {sr_reg[SR_W-2:0], ref_c};
               err_c = ~ign_c & (rx_c ^ ref_c);
               cnt_c = ~ign_c; // RQ9
               werr_next = werr_reg + {5'h00, err_c};
               cnt_next = cnt_reg + 6'h01;
               if (cnt_reg == 6'(LOCK_WIN - 1)) begin
                  cnt_next = 6'h00;
                  // A seed taken with an error gives about half the bits wrong.
                  if (werr_next >= 6'(LOCK_ERR_MAX)) begin
                     sy_next = SY_SEED; // RQ18
                     flock_next = 1'b1;
                  end
                  werr_next = 6'h00;
               end
            end
            default: sy_next = SY_SEED;
         endcase
      end
      if (sy_reg == SY_LOCK) begin
         syn_stat_next = STAT_OK; // RQ14 RQ20
      end else begin
         syn_stat_next = flock_reg ? STAT_FAULT : STAT_MISSING; // RQ18 RQ20
      end

      case (ms_reg)
         MS_IDLE, MS_DONE: begin
            if ((run_enable & mode_single & exec_single) |
               (ms_reg == MS_IDLE & run_enable & ~mode_single)) begin
               ms_next = MS_RUN; // RQ4 RQ5
               bits_next = '0;
               errs_next = '0;
               sbits_next = '0; // RQ11
               serrs_next = '0;
               first_next = 1'b1;
               cause_next = CAUSE_NONE;
               refr_next = 10'h000;
               load_c = 1'b1;
            end else if (ms_reg == MS_DONE && !run_enable) begin
               ms_next = MS_IDLE;
            end
         end
         MS_RUN: begin
            nb_c = (bits_reg == '1) ? bits_reg : bits_reg + 32'h0000_0001;
            ne_c = (errs_reg == '1) ? errs_reg : errs_reg + {31'h0, err_c};
            if (!run_enable || stop_cmd) begin
               ms_next = MS_DONE;
               cause_next = CAUSE_USER; // RQ10
               sbits_next = bits_reg; // RQ11
               serrs_next = errs_reg;
               load_c = 1'b1;
            end else if (cnt_c) begin
               bits_next = nb_c; // RQ9 RQ21
               errs_next = ne_c; // RQ21
               hit_b = max_bits_en & (nb_c >= max_bits); // RQ7
               hit_e = max_errs_en & (ne_c >= max_errs); // RQ8
               if (hit_b || hit_e) begin
                  cause_next = hit_b ? CAUSE_BITS : CAUSE_ERRS; // RQ7 RQ8 RQ22
                  sbits_next = nb_c;
                  serrs_next = ne_c;
                  load_c = 1'b1;
                  if (mode_single) begin
                     ms_next = MS_DONE; // RQ4
                  end else begin
                     bits_next = '0; // RQ2
                     errs_next = '0;
                     first_next = 1'b0;
                  end
               end else if (!mode_single && first_reg) begin
                  sbits_next = nb_c; // RQ3
                  serrs_next = ne_c;
                  load_c = 1'b1;
               end
            end
            if (mode_single && ms_next == MS_RUN) begin
               if (refr_reg == 10'(REFRESH_CYC - 1)) begin
                  refr_next = 10'h000;
                  sbits_next = bits_next; // RQ6
                  serrs_next = errs_next;
                  load_c = 1'b1;
               end else begin
                  refr_next = refr_reg + 10'h001;
               end
            end
         end
         default: ms_next = MS_IDLE;
      endcase

      // Serial divider; a new load restarts it, so the rate lags the counts.
      if (load_c) begin
         num_next = NUM_W'(serrs_next) * NUM_W'(PPM_SCALE); // RQ1
         den_next = sbits_next;
         rem_next = '0;
         q_next = '0;
         dcnt_next = 6'h00;
         dbusy_next = 1'b1;
      end else if (dbusy_reg) begin
         trial_c = {rem_reg[CNT_W-1:0], num_reg[NUM_W-1]};
         num_next = {num_reg[NUM_W-2:0], 1'b0};
         if (trial_c >= {1'b0, den_reg}) begin
            rem_next = trial_c - {1'b0, den_reg};
            q_next = {q_reg[PPM_W-2:0], 1'b1};
         end else begin
            rem_next = trial_c;
            q_next = {q_reg[PPM_W-2:0], 1'b0};
         end
         dcnt_next = dcnt_reg + 6'h01;
         if (dcnt_reg == 6'(NUM_W - 1)) begin
            dbusy_next = 1'b0;
            ppm_next = (den_reg == '0) ? '0 : q_next; // RQ1
         end
      end
      busy_next = (ms_next == MS_RUN);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gap_reg <= 8'h00;
         clk_stat_reg <= STAT_MISSING;
         dat_stat_reg <= STAT_MISSING;
         syn_stat_reg <= STAT_MISSING;
         dat_prev_reg <= 1'b0;
         idle_reg <= 8'h00;
         sy_reg <= SY_SEED;
         sr_reg <= '0;
         cnt_reg <= 6'h00;
         werr_reg <= 6'h00;
         ign_reg <= 6'h00;
         flock_reg <= 1'b0;
         ms_reg <= MS_IDLE;
         bits_reg <= '0;
         errs_reg <= '0;
         sbits_reg <= '0;
         serrs_reg <= '0;
         first_reg <= 1'b0;
         busy_reg <= 1'b0;
         cause_reg <= CAUSE_NONE;
         refr_reg <= 10'h000;
         num_reg <= '0;
         den_reg <= '0;
         rem_reg <= '0;
         q_reg <= '0;
         ppm_reg <= '0;
         dcnt_reg <= 6'h00;
         dbusy_reg <= 1'b0;
      end else if (clk_en) begin
         gap_reg <= gap_next;
         clk_stat_reg <= clk_stat_next;
         dat_stat_reg <= dat_stat_next;
         syn_stat_reg <= syn_stat_next;
         dat_prev_reg <= dat_prev_next;
         idle_reg <= idle_next;
         sy_reg <= sy_next;
         sr_reg <= sr_next;
         cnt_reg <= cnt_next;
         werr_reg <= werr_next;
         ign_reg <= ign_next;
         flock_reg <= flock_next;
         ms_reg <= ms_next;
         bits_reg <= bits_next;
         errs_reg <= errs_next;
         sbits_reg <= sbits_next;
         serrs_reg <= serrs_next;
         first_reg <= first_next;
         busy_reg <= busy_next;
         cause_reg <= cause_next;
         refr_reg <= refr_next;
         num_reg <= num_next;
         den_reg <= den_next;
         rem_reg <= rem_next;
         q_reg <= q_next;
         ppm_reg <= ppm_next;
         dcnt_reg <= dcnt_next;
         dbusy_reg <= dbusy_next;
      end
   end

   assign live_bits = bits_reg;
   assign live_errs = errs_reg;
   assign shown_bits = sbits_reg;
   assign shown_errs = serrs_reg;
   assign ber_ppm = ppm_reg;
   assign term_cause = cause_reg;
   assign meas_busy = busy_reg;
   assign clk_status = clk_stat_reg;
   assign data_status = dat_stat_reg;
   assign sync_status = syn_stat_reg;

endmodule : pberc_checker

// >>> hw/pberc_pkg.sv
package pberc_pkg;

   localparam int CNT_W = 32;
   localparam int SR_W = 23;
   localparam int PPM_W = 20;
   localparam int NUM_W = 52;

   localparam logic [2:0] PRBS_9 = 3'h0;
   localparam logic [2:0] PRBS_11 = 3'h1;
   localparam logic [2:0] PRBS_15 = 3'h2;
   localparam logic [2:0] PRBS_16 = 3'h3;
   localparam logic [2:0] PRBS_20 = 3'h4;
   localparam logic [2:0] PRBS_21 = 3'h5;
   localparam logic [2:0] PRBS_23 = 3'h6;

   localparam logic [1:0] STAT_OK = 2'h0;
   localparam logic [1:0] STAT_MISSING = 2'h1;
   localparam logic [1:0] STAT_FAULT = 2'h2;

   localparam logic [1:0] CAUSE_NONE = 2'h0;
   localparam logic [1:0] CAUSE_USER = 2'h1;
   localparam logic [1:0] CAUSE_BITS = 2'h2;
   localparam logic [1:0] CAUSE_ERRS = 2'h3;

   localparam logic [1:0] DEN_OFF = 2'h0;
   localparam logic [1:0] DEN_HIGH = 2'h1;
   localparam logic [1:0] DEN_LOW = 2'h2;

   localparam logic [1:0] IGN_OFF = 2'h0;
   localparam logic [1:0] IGN_ONES = 2'h1;
   localparam logic [1:0] IGN_ZEROS = 2'h2;

   localparam int SYS_MHZ = 10;
   localparam int CLK_LOSS_NS = 10000;
   localparam int CLK_LOSS_CYC = (CLK_LOSS_NS * SYS_MHZ + 999) / 1000;
   localparam int CLK_MIN_NS = 200;
   localparam int CLK_MIN_CYC = (CLK_MIN_NS * SYS_MHZ + 999) / 1000;
   localparam int REFRESH_NS = 100000;
   localparam int REFRESH_CYC = (REFRESH_NS * SYS_MHZ) / 1000;

   localparam int DATA_IDLE_BITS = 255;
   localparam int SYNC_RUN = 32;
   localparam int LOCK_WIN = 64;
   localparam int LOCK_ERR_MAX = 24;
   localparam int IGN_RUN = 32;
   localparam logic [NUM_W-CNT_W-1:0] PPM_SCALE = 20'hF_4240;

   typedef enum logic [1:0] {SY_SEED, SY_CHECK, SY_LOCK} pberc_sync_type;
   typedef enum logic [1:0] {MS_IDLE, MS_RUN, MS_DONE} pberc_meas_type;

endpackage : pberc_pkg

// >>> verif/pberc_checker_properties.sv
module pberc_checker_props
   import pberc_pkg::*;
(
   input wire logic sys_clk, // System clock.
   input wire logic srst, // Synchronous reset.
   input wire logic clk_en, // Clock enable.
   input wire logic meas_clk_pin, // Measurement clock.
   input wire logic run_enable, // Measurement on.
   input wire logic mode_single, // Single shot selected.
   input wire logic exec_single, // Execute pulse.
   input wire logic stop_cmd, // Stop pulse.
   input wire logic max_errs_en, // Error limit on.
   input wire logic [CNT_W-1:0] max_bits, // Bit limit.
   input wire logic [CNT_W-1:0] max_errs, // Error limit.
   input wire logic [CNT_W-1:0] live_bits, // Running bits.
   input wire logic [CNT_W-1:0] live_errs, // Running errors.
   input wire logic [CNT_W-1:0] shown_bits, // Shown bits.
   input wire logic [1:0] term_cause, // Cause.
   input wire logic meas_busy, // Running.
   input wire logic [1:0] clk_status, // Clock status.
   input wire logic [1:0] data_status, // Data status.
   input wire logic [1:0] sync_status // Sync status.
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   logic last_reg, last_next;
   logic [7:0] quiet_reg, quiet_next;
   // Cycles since the clock pin last moved, saturating.
   always_comb begin
      last_next = meas_clk_pin;
      quiet_next = quiet_reg;
      if (meas_clk_pin != last_reg) begin
         quiet_next = 8'h00;
      end else if (quiet_reg != 8'hFF) begin
         quiet_next = quiet_reg + 8'h01;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         last_reg <= 1'b0;
         quiet_reg <= 8'h00;
      end else begin
         last_reg <= last_next;
         quiet_reg <= quiet_next;
      end
   end
   property p_exec_start;
      exec_single && mode_single && run_enable && clk_en && !stop_cmd && !meas_busy
         |=> meas_busy;
   endproperty
   a_exec_start: assert property (p_exec_start) else $error("execute did not start");
   property p_exec_refused;
      exec_single && !run_enable && !meas_busy |=> !meas_busy;
   endproperty
   a_exec_refused: assert property (p_exec_refused) else $error("refused execute ran");
   property p_hold;
      !meas_busy && mode_single && !exec_single |=> $stable(term_cause) && $stable(shown_bits);
   endproperty
   a_hold: assert property (p_hold) else $error("final results changed");
   property p_stop;
      meas_busy && stop_cmd && clk_en |=> !meas_busy && term_cause == CAUSE_USER;
   endproperty
   a_stop: assert property (p_stop) else $error("user stop not recorded");
   property p_bits_end;
      $fell(meas_busy) && term_cause == CAUSE_BITS |-> live_bits == max_bits;
   endproperty
   a_bits_end: assert property (p_bits_end) else $error("bit limit end wrong");
   property p_errs_end;
      $fell(meas_busy) && term_cause == CAUSE_ERRS |-> live_errs == max_errs && max_errs_en;
   endproperty
   a_errs_end: assert property (p_errs_end) else $error("error limit end wrong");
   property p_sync_dep;
      (clk_status != STAT_OK || data_status != STAT_OK) [*3] |-> sync_status != STAT_OK;
   endproperty
   a_sync_dep: assert property (p_sync_dep) else $error("sync without clock or data");
   property p_clk_lost;
      quiet_reg >= 8'h78 |-> clk_status == STAT_MISSING;
   endproperty
   a_clk_lost: assert property (p_clk_lost) else $error("lost clock not reported");
endmodule : pberc_checker_props

bind pberc_checker pberc_checker_props u_props (.sys_clk(sys_clk), .srst(srst),
   .clk_en(clk_en), .meas_clk_pin(meas_clk_pin), .run_enable(run_enable),
   .mode_single(mode_single), .exec_single(exec_single), .stop_cmd(stop_cmd),
   .max_errs_en(max_errs_en), .max_bits(max_bits), .max_errs(max_errs),
   .live_bits(live_bits), .live_errs(live_errs), .shown_bits(shown_bits),
   .term_cause(term_cause), .meas_busy(meas_busy), .clk_status(clk_status),
   .data_status(data_status), .sync_status(sync_status));

// >>> verif/pberc_checker_test.sv
module pberc_checker_test
   import pberc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, srst, data_en_pin, run_enable, mode_single, exec_single, stop_cmd;
   logic max_bits_en, max_errs_en, src_on, err_on, meas_clk, meas_data, meas_busy;
   logic [2:0] prbs_sel, src_poly;
   logic [1:0] den_mode, term_cause, clk_status, data_status, sync_status;
   logic [CNT_W-1:0] max_bits, max_errs, live_bits, live_errs, shown_bits, shown_errs;
   logic [PPM_W-1:0] ber_ppm;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;

   pberc_checker dut (.sys_clk(sys_clk), .srst(srst), .clk_en(1'b1), .meas_clk_pin(meas_clk),
      .meas_data_pin(meas_data), .data_en_pin(data_en_pin), .run_enable(run_enable),
      .mode_single(mode_single), .exec_single(exec_single), .stop_cmd(stop_cmd),
      .prbs_sel(prbs_sel), .den_mode(den_mode), .ign_mode(IGN_OFF), .max_bits_en(max_bits_en),
      .max_bits(max_bits), .max_errs_en(max_errs_en), .max_errs(max_errs),
      .live_bits(live_bits), .live_errs(live_errs), .shown_bits(shown_bits),
      .shown_errs(shown_errs), .ber_ppm(ber_ppm), .term_cause(term_cause),
      .meas_busy(meas_busy), .clk_status(clk_status), .data_status(data_status),
      .sync_status(sync_status));
   pberc_prbs_source src (.active(src_on), .poly(src_poly), .err_on(err_on),
      .clk_out(meas_clk), .data_out(meas_data));

   task automatic report_and_stop();
      if (errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   task automatic pulse_exec();
      exec_single <= 1'b1;
      tick(1);
      exec_single <= 1'b0;
      tick(2);
   endtask : pulse_exec
   task automatic wait_idle(input int n);
      for (int i = 0; i < n && meas_busy !== 1'b0; i++) tick(1);
   endtask : wait_idle
   task automatic wait_sync(input int n);
      for (int i = 0; i < n && sync_status !== STAT_OK; i++) tick(1);
   endtask : wait_sync

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Ceiling well above the roughly 11000 cycles the run needs.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      srst = 1'b1;
      data_en_pin = 1'b0;
      run_enable = 1'b0;
      mode_single = 1'b1;
      exec_single = 1'b0;
      stop_cmd = 1'b0;
      max_bits_en = 1'b1;
      max_errs_en = 1'b0;
      src_on = 1'b0;
      err_on = 1'b0;
      prbs_sel = PRBS_9;
      src_poly = PRBS_9;
      den_mode = DEN_OFF;
      max_bits = 32'h0000_0064;
      max_errs = 32'h0000_000A;
      tick(5);
      srst <= 1'b0;
      tick(2);
      check_val(clk_status, STAT_MISSING);
      check_val(sync_status, STAT_MISSING);
      src_on <= 1'b1;
      wait_sync(3000);
      check_val(clk_status, STAT_OK);
      check_val(data_status, STAT_OK);
      check_val(sync_status, STAT_OK);
      pulse_exec();
      check_val(meas_busy, 1'b0);
      run_enable <= 1'b1;
      pulse_exec();
      check_val(meas_busy, 1'b1);
      wait_idle(1500);
      check_val(term_cause, CAUSE_BITS);
      check_val(live_bits, 32'h0000_0064);
      check_val(live_errs, 32'h0000_0000);
      tick(300);
      check_val(ber_ppm, 20'h0_0000);
      check_val(shown_bits, 32'h0000_0064);
      check_val(meas_busy, 1'b0);
      max_bits <= 32'h0000_03E8;
      max_errs_en <= 1'b1;
      err_on <= 1'b1;
      pulse_exec();
      wait_idle(1500);
      check_val(term_cause, CAUSE_ERRS);
      check_val(live_errs, 32'h0000_000A);
      check_val(shown_errs, 32'h0000_000A);
      tick(60);
      check_val(ber_ppm, 32'((64'(shown_errs) * 64'hF_4240) / shown_bits));
      err_on <= 1'b0;
      max_errs_en <= 1'b0;
      run_enable <= 1'b0;
      tick(3);
      max_bits <= 32'h0000_0032;
      mode_single <= 1'b0;
      run_enable <= 1'b1;
      tick(1100);
      check_val(meas_busy, 1'b1);
      check_val(term_cause, CAUSE_BITS);
      check_val(shown_bits, 32'h0000_0032);
      run_enable <= 1'b0;
      tick(3);
      check_val(term_cause, CAUSE_USER);
      mode_single <= 1'b1;
      run_enable <= 1'b1;
      max_bits_en <= 1'b0;
      den_mode <= DEN_HIGH;
      pulse_exec();
      tick(300);
      check_val(live_bits, 32'h0000_0000);
      data_en_pin <= 1'b1;
      tick(100);
      stop_cmd <= 1'b1;
      tick(1);
      stop_cmd <= 1'b0;
      tick(2);
      check_val(term_cause, CAUSE_USER);
      check_val(meas_busy, 1'b0);
      den_mode <= DEN_OFF;
      // Losing the clock forces a fresh seed; the last pass sends a wrong polynomial.
      for (int p = 0; p < 8; p++) begin
         src_on <= 1'b0;
         prbs_sel <= (p < 7) ? p[2:0] : PRBS_9;
         src_poly <= (p < 7) ? p[2:0] : PRBS_11;
         tick(150);
         src_on <= 1'b1;
         wait_sync(3000);
         check_val(sync_status == STAT_OK, p < 7);
      end
      src_on <= 1'b0;
      tick(200);
      check_val(clk_status, STAT_MISSING);
      report_and_stop();
   end
endmodule : pberc_checker_test

// >>> verif/pberc_prbs_source.sv
module pberc_prbs_source
   import pberc_pkg::*;
(
   input wire logic active, // Clock runs while high.
   input wire logic [2:0] poly, // Polynomial sent.
   input wire logic err_on, // Inverts every fourth bit while high.
   output logic clk_out, // Measurement clock, still while inactive.
   output logic data_out // Serial data.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [SR_W-1:0] sr_reg;
   logic [1:0] cnt_reg;
   logic bit_next;
   function automatic logic fb(input logic [SR_W-1:0] s, input logic [2:0] p);
      case (p)
         PRBS_11: return s[10] ^ s[8];
         PRBS_15: return s[14] ^ s[13];
         PRBS_16: return s[15] ^ s[13] ^ s[12] ^ s[10];
         PRBS_20: return s[19] ^ s[2];
         PRBS_21: return s[20] ^ s[18];
         PRBS_23: return s[22] ^ s[17];
         default: return s[8] ^ s[4];
      endcase
   endfunction : fb
   // Data moves at the falling edge so it is stable for a full period around each rise.
   initial begin
      clk_out = 1'b0;
      data_out = 1'b0;
      sr_reg = '1;
      cnt_reg = 2'h0;
      forever begin
         #400;
         if (active) begin
            clk_out = 1'b1;
            #400;
            clk_out = 1'b0;
            bit_next = fb(sr_reg, poly);
            sr_reg = {sr_reg[SR_W-2:0], bit_next};
            cnt_reg = cnt_reg + 2'h1;
            data_out = bit_next ^ (poly == PRBS_15 || poly == PRBS_23) ^ (err_on && cnt_reg == 2'h0);
         end else begin
            // An idle line keeps moving so a stale level is never mistaken for data.
            data_out = ~data_out;
            #400;
         end
      end
   end
endmodule : pberc_prbs_source
